// [hdl/plk_link_setup.sv]
// Strap decode, half routing, sideband and lane ownership of the packet link
// Function
// - Split strap high: two independent 8-bit links
// - Split: address bit 40 selects the half
// - Not split: low half runs all, high invalid
// - Master half drives power-good, reset, stop lines
// - Role flag reset value from master strap
// - Bridge bit is inverse of role flag
// - Window miss: forward peer-to-peer or error
// - High sideband lines ignored unless split
// - Clock lanes follow split ownership
// - Control lane 1 unused when not split
// - Data lanes follow split ownership
// - Initialisation starts by itself after reset
// - Cold start at 200 MHz, 8 bits
// - Initialisation complete status readable
// - Established widths reported after initialisation
// - New settings apply on warm reset, stop
// - Both ends need matching width, rate settings
// - Rates 200, 400 and 800 MHz
// - Widths 8 and 16 bits per direction
// - Port zero coherent, port one not
`timescale 1ns/10ps
module plk_link_setup
  import plk_pkg::*;
#(
  parameter int PORT_INDEX = 0,
  parameter int BUF_DEPTH  = 2
)(
  // Clock and reset
  input  wire logic              CLOCK,
  input  wire logic              RESET,
  // Strap pins
  input  wire logic              LINK_SPLIT_STRAP,
  input  wire logic              LOW_HALF_MASTER_STRAP,
  input  wire logic              HIGH_HALF_MASTER_STRAP,
  // Forwarded link clock and receive control lanes
  input  wire logic              LINK_CLK,
  input  wire logic [1:0]        RX_CTL,
  // Transmit lanes
  output logic [1:0]             TX_CLK,
  output logic [1:0]             TX_CTL,
  output logic [15:0]            TX_CAD,
  // Sideband lines, index 0 low half, index 1 high half
  input  wire logic [1:0]        POWER_GOOD_LINE_IN,
  output logic [1:0]             POWER_GOOD_LINE_OUT,
  output logic [1:0]             POWER_GOOD_LINE_OE,
  input  wire logic [1:0]        LINK_RESET_LINE_N_IN,
  output logic [1:0]             LINK_RESET_LINE_N_OUT,
  output logic [1:0]             LINK_RESET_LINE_N_OE,
  input  wire logic [1:0]        LINK_STOP_LINE_N_IN,
  output logic [1:0]             LINK_STOP_LINE_N_OUT,
  output logic [1:0]             LINK_STOP_LINE_N_OE,
  input  wire logic [1:0]        LINK_REQUEST_LINE_N_IN,
  // Internal outbound word stream
  input  wire logic              ACC_VALID,
  input  wire logic [ADDR_W-1:0] ACC_ADDR,
  input  wire logic [15:0]       ACC_DATA,
  output logic [1:0]             ACC_READY,
  output logic                   ACC_DROP,
  // Inbound request window verdict
  input  wire logic              RXQ_VALID,
  input  wire logic              RXQ_HIGH,
  input  wire logic              RXQ_HIT,
  output logic                   RXQ_ACCEPT,
  output logic                   RXQ_P2P,
  output logic                   RXQ_ERROR,
  // Control
  input  wire logic [1:0]        ROLE_WE,
  input  wire logic [1:0]        ROLE_WDATA,
  input  wire logic [1:0]        WARM_RESET,
  input  wire logic [1:0]        CFG_WIDTH_OUT,
  input  wire logic [1:0]        CFG_WIDTH_IN,
  input  wire logic [3:0]        CFG_FREQ,
  // Status
  output logic [1:0]             ENDPOINT_ROLE_FLAG,
  output logic [1:0]             BRIDGE_BIT,
  output logic [1:0]             INIT_COMPLETE,
  output logic [1:0]             LINK_WIDTH_OUT,
  output logic [1:0]             LINK_WIDTH_IN,
  output logic [3:0]             LINK_FREQ,
  output logic [1:0]             PEER_REQUEST,
  output logic                   SPLIT_ACTIVE,
  output logic                   COHERENT
);
  typedef struct packed {
    logic [2:0]  s1_strap;
    logic [2:0]  s2_strap;
    logic [2:0]  strap;      // split, high master, low master
    logic [1:0]  settle;
    logic        captured;
    logic [7:0]  s1_sb;      // per half: request, stop, reset, power good
    logic [7:0]  s2_sb;
    logic [2:0]  s1_lk;      // link clock, control lanes
    logic [2:0]  s2_lk;
    logic        lclk_prev;
    logic [1:0]  role;
    logic [1:0]  bridge;
    logic [1:0]  done;
    logic [1:0]  wo;
    logic [1:0]  wi;
    logic [3:0]  freq;
    logic [1:0]  phase;
    logic [1:0]  txclk;
    logic [1:0]  txctl;
    logic [15:0] cad;
    logic [1:0]  pg_o;
    logic [1:0]  pg_oe;
    logic [1:0]  rst_o;
    logic [1:0]  rst_oe;
    logic [1:0]  stop_o;
    logic [1:0]  stop_oe;
    logic [1:0]  peer_req;
    logic        drop;
    logic        accept;
    logic        p2p;
    logic        err;
    logic        split;
    logic        coherent;
  } plk_top_t;

  plk_top_t          r;
  plk_top_t          n;
  logic              tick;
  logic              sel_hi;
  logic [1:0]        half_en;
  logic [1:0]        drive;
  logic [1:0]        init_rst_n;
  logic [1:0]        init_ctl;
  logic [1:0]        init_done;
  logic [1:0]        init_wo;
  logic [1:0]        init_wi;
  logic [3:0]        init_freq;
  logic [1:0]        cfg_wo;
  logic [1:0]        peer_up;
  logic [1:0]        peer_ctl;
  logic [1:0]        stop_n;
  logic [1:0]        buf_in_valid;
  logic [1:0]        buf_in_ready;
  logic [1:0]        buf_out_valid;
  logic [1:0][15:0]  buf_out_data;
  logic [1:0]        buf_out_ready;
  logic [1:0]        wide;
  logic [1:0]        send;

  // Edge of the sampled link clock; only the second sync stage is looked at
  assign tick   = r.s2_lk[2] && !r.lclk_prev;
  // Address bit 40 picks the half only when split
  assign sel_hi = r.strap[2] && ACC_ADDR[ROUTE_BIT];

  // Per-half enables and handshakes into the sequencers
  always_comb begin
    for (int h = 0; h < 2; h++) begin
      half_en[h]  = r.captured && (h == 0 || r.strap[2]);
      drive[h]    = half_en[h] && r.strap[h];
      peer_up[h]  = r.s2_sb[h*4] && r.s2_sb[h*4+1];
      stop_n[h]   = r.s2_sb[h*4+2];
      peer_ctl[h] = r.s2_lk[h];
      wide[h]     = (h == 0) && !r.strap[2] && init_wo[0];
      send[h]     = tick && init_done[h] && buf_out_valid[h];
      buf_out_ready[h] = send[h] && (wide[h] || r.phase[h]);
    end
    cfg_wo[0]       = CFG_WIDTH_OUT[0] && !r.strap[2];
    cfg_wo[1]       = WIDTH_8;
    buf_in_valid[0] = ACC_VALID && !ACC_ADDR[ROUTE_BIT];
    buf_in_valid[1] = ACC_VALID && sel_hi;
  end

  // One bring-up sequencer and one transmit buffer per half
  for (genvar g = 0; g < 2; g++) begin : g_half
    plk_half_init u_init (
      .clk          (CLOCK),
      .rst          (RESET),
      .enable       (half_en[g]),
      .master       (r.strap[g]),
      .tick         (tick),
      .stop_n       (stop_n[g]),
      .peer_up      (peer_up[g]),
      .peer_ctl     (peer_ctl[g]),
      .warm_req     (WARM_RESET[g]),
      .cfg_wide_out (cfg_wo[g]),
      .cfg_wide_in  (CFG_WIDTH_IN[g] && g == 0 && !r.strap[2]),
      .cfg_freq     (CFG_FREQ[g*2 +: 2]),
      .link_rst_n   (init_rst_n[g]),
      .ctl_drive    (init_ctl[g]),
      .done         (init_done[g]),
      .wide_out     (init_wo[g]),
      .wide_in      (init_wi[g]),
      .freq         (init_freq[g*2 +: 2])
    );
    plk_buf2 #(
      .W     (16),
      .DEPTH (BUF_DEPTH)
    ) u_buf (
      .clk       (CLOCK),
      .rst       (RESET),
      .in_valid  (buf_in_valid[g]),
      .in_data   (ACC_DATA),
      .in_ready  (buf_in_ready[g]),
      .out_valid (buf_out_valid[g]),
      .out_data  (buf_out_data[g]),
      .out_ready (buf_out_ready[g])
    );
  end

  // Next state of the top: sync, straps, status, lanes, sideband, verdicts
  always_comb begin
    n           = r;
    n.s1_strap  = {LINK_SPLIT_STRAP, HIGH_HALF_MASTER_STRAP, LOW_HALF_MASTER_STRAP};
    n.s2_strap  = r.s1_strap;
    n.s1_sb     = {LINK_REQUEST_LINE_N_IN[1], LINK_STOP_LINE_N_IN[1],
                   LINK_RESET_LINE_N_IN[1], POWER_GOOD_LINE_IN[1],
                   LINK_REQUEST_LINE_N_IN[0], LINK_STOP_LINE_N_IN[0],
                   LINK_RESET_LINE_N_IN[0], POWER_GOOD_LINE_IN[0]};
    n.s2_sb     = r.s1_sb;
    n.s1_lk     = {LINK_CLK, RX_CTL};
    n.s2_lk     = r.s1_lk;
    n.lclk_prev = r.s2_lk[2];
    // Straps follow the pins only until the settle window closes
    if (!r.captured) begin
      n.strap = r.s2_strap;
      if (r.settle == 2'(STRAP_SETTLE_CYCLES - 1)) begin
        n.captured = 1'b1;
        for (int h = 0; h < 2; h++) begin
          n.role[h] = r.s2_strap[h] ? ROLE_RESET_MASTER : !ROLE_RESET_MASTER;
        end
      end else begin
        n.settle = r.settle + 2'h1;
      end
    end else begin
      for (int h = 0; h < 2; h++) begin
        if (ROLE_WE[h]) begin
          n.role[h] = ROLE_WDATA[h];
        end
      end
    end
    n.bridge   = ~n.role;
    n.split    = r.captured && r.strap[2];
    n.coherent = (PORT_INDEX == 0);
    // Widths read as narrow until the handshake has finished
    for (int h = 0; h < 2; h++) begin
      n.done[h]          = init_done[h];
      n.wo[h]            = init_done[h] ? init_wo[h] : WIDTH_8;
      n.wi[h]            = init_done[h] ? init_wi[h] : WIDTH_8;
      n.freq[h*2 +: 2]   = init_done[h] ? init_freq[h*2 +: 2] : FREQ_200;
      n.pg_oe[h]         = drive[h];
      n.rst_oe[h]        = drive[h];
      n.stop_oe[h]       = drive[h];
      n.pg_o[h]          = drive[h];
      n.rst_o[h]         = drive[h] && init_rst_n[h];
      n.stop_o[h]        = drive[h];
      n.peer_req[h]      = half_en[h] && !r.s2_sb[h*4+3];
    end
    // Lanes move only on link clock edges; each half owns its lanes when split, otherwise the low half drives all but control lane 1, held low
    if (tick) begin
      for (int h = 0; h < 2; h++) begin
        if (send[h] && !wide[h]) begin
          n.phase[h] = !r.phase[h];
        end
      end
      n.txclk[0] = half_en[0] ? !r.txclk[0] : 1'b0;
      n.txclk[1] = r.strap[2] ? (half_en[1] ? !r.txclk[1] : 1'b0) : n.txclk[0];
      n.txctl[0] = init_ctl[0] && (!init_done[0] || send[0]);
      n.txctl[1] = r.strap[2] && init_ctl[1] && (!init_done[1] || send[1]);
      if (wide[0]) begin
        n.cad = send[0] ? buf_out_data[0] : 16'h0000;
      end else begin
        n.cad[7:0]  = !send[0] ? 8'h00 :
                      (r.phase[0] ? buf_out_data[0][15:8] : buf_out_data[0][7:0]);
        n.cad[15:8] = (!send[1] || !r.strap[2]) ? 8'h00 :
                      (r.phase[1] ? buf_out_data[1][15:8] : buf_out_data[1][7:0]);
      end
    end
    // Inbound verdict; the high half counts only when split
    n.drop   = ACC_VALID && ACC_ADDR[ROUTE_BIT] && !r.strap[2];
    n.accept = 1'b0;
    n.p2p    = 1'b0;
    n.err    = 1'b0;
    if (RXQ_VALID && r.captured && (!RXQ_HIGH || r.strap[2])) begin
      n.accept = RXQ_HIT;
      n.p2p    = !RXQ_HIT && !r.role[RXQ_HIGH];
      n.err    = !RXQ_HIT && r.role[RXQ_HIGH];
    end
  end

  // State register
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      r <= '{bridge: 2'h3, default: '0};
    end else begin
      r <= n;
    end
  end

  // Ports come from the registered state, ready from the buffer registers
  assign TX_CLK                = r.txclk;
  assign TX_CTL                = r.txctl;
  assign TX_CAD                = r.cad;
  assign POWER_GOOD_LINE_OUT   = r.pg_o;
  assign POWER_GOOD_LINE_OE    = r.pg_oe;
  assign LINK_RESET_LINE_N_OUT = r.rst_o;
  assign LINK_RESET_LINE_N_OE  = r.rst_oe;
  assign LINK_STOP_LINE_N_OUT  = r.stop_o;
  assign LINK_STOP_LINE_N_OE   = r.stop_oe;
  assign ACC_READY             = buf_in_ready;
  assign ACC_DROP              = r.drop;
  assign RXQ_ACCEPT            = r.accept;
  assign RXQ_P2P               = r.p2p;
  assign RXQ_ERROR             = r.err;
  assign ENDPOINT_ROLE_FLAG    = r.role;
  assign BRIDGE_BIT            = r.bridge;
  assign INIT_COMPLETE         = r.done;
  assign LINK_WIDTH_OUT        = r.wo;
  assign LINK_WIDTH_IN         = r.wi;
  assign LINK_FREQ             = r.freq;
  assign PEER_REQUEST          = r.peer_req;
  assign SPLIT_ACTIVE          = r.split;
  assign COHERENT              = r.coherent;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);

  sequence low_miss_s;
    RXQ_VALID && r.captured && !RXQ_HIGH && !RXQ_HIT;
  endsequence
  sequence drop_seen_s;
    ##1 ACC_DROP;
  endsequence

  bridge_role_a: assert property (BRIDGE_BIT == ~ENDPOINT_ROLE_FLAG)
    else $error("bridge bit does not mirror role flag");
  miss_verdict_a: assert property (low_miss_s |=>
    RXQ_P2P == !$past(r.role[0]) && RXQ_ERROR == $past(r.role[0]) && !RXQ_ACCEPT)
    else $error("window miss answered wrongly for role");
  high_route_a: assert property (ACC_VALID && ACC_ADDR[ROUTE_BIT] && !r.strap[2]
    |-> !buf_in_valid[1] && !buf_in_valid[0] ##0 drop_seen_s)
    else $error("upper address reached a half while not split");
  split_route_a: assert property (ACC_VALID && r.strap[2]
    |-> buf_in_valid[1] == ACC_ADDR[ROUTE_BIT] && buf_in_valid[0] == !ACC_ADDR[ROUTE_BIT])
    else $error("split access sent to wrong half");
  high_ignore_a: assert property (r.captured && !r.strap[2] |=>
    !POWER_GOOD_LINE_OE[1] && !LINK_RESET_LINE_N_OE[1] && !PEER_REQUEST[1])
    else $error("high sideband active while not split");
  ctl_unused_a: assert property (r.captured && !r.strap[2] |=> !TX_CTL[1])
    else $error("control lane 1 driven while not split");
  clk_lane_a: assert property (r.captured && !r.strap[2] ##1 r.captured
    |-> TX_CLK[1] == TX_CLK[0])
    else $error("clock lanes differ while not split");
  master_drive_a: assert property (drive[0] |=>
    POWER_GOOD_LINE_OE[0] && LINK_STOP_LINE_N_OE[0] && LINK_RESET_LINE_N_OE[0])
    else $error("master half left sideband undriven");
  strap_hold_a: assert property (r.captured |=> $stable(r.strap) && r.captured)
    else $error("straps changed after capture");
endmodule

// [hdl/plk_pkg.sv]
// Shared constants and types of the packet link setup block
package plk_pkg;
  // Clock rate of the block
  localparam int CLOCK_MHZ           = 25;
  // Lane layout and address routing
  localparam int LANE_COUNT          = 16;
  localparam int HALF_LANES          = 8;
  localparam int ROUTE_BIT           = 40;
  localparam int ADDR_W              = 48;
  // Strap settle time after reset release, in clock cycles
  localparam int STRAP_SETTLE_CYCLES = 3;
  // Link reset pulse driven by a master half, least time
  localparam int LINK_RESET_NS       = 1000;
  localparam int LINK_RESET_CYCLES   = (LINK_RESET_NS * CLOCK_MHZ + 999) / 1000;
  // Link clock edges of steady peer control needed to finish training
  localparam int TRAIN_TICKS         = 16;
  // Link rate codes
  localparam logic [1:0] FREQ_200    = 2'h0;
  localparam logic [1:0] FREQ_400    = 2'h1;
  localparam logic [1:0] FREQ_800    = 2'h2;
  // Link width codes
  localparam logic WIDTH_8           = 1'b0;
  localparam logic WIDTH_16          = 1'b1;
  // Role flag value loaded for a half strapped as master
  localparam logic ROLE_RESET_MASTER = 1'b0;
  // Per-half initialisation states
  typedef enum logic [3:0] {
    PLK_HOLD  = 4'h1,
    PLK_LRST  = 4'h2,
    PLK_TRAIN = 4'h4,
    PLK_UP    = 4'h8
  } plk_state_t;
endpackage

// [hdl/plk_buf2.sv]
// Small valid/ready buffer in front of each half's transmit lanes
`timescale 1ns/10ps
module plk_buf2
  import plk_pkg::*;
#(
  parameter int W     = 16,
  parameter int DEPTH = 2
)(
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Fill side
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  // Drain side
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           rd;
    logic [AW-1:0]           wr;
    logic [CW-1:0]           cnt;
    logic                    rdy;
  } plk_buf_t;

  plk_buf_t r;
  plk_buf_t n;
  logic     push;
  logic     pop;

  // Pointer and count update; ready is registered so it can never glitch
  always_comb begin
    n    = r;
    push = in_valid && r.rdy;
    pop  = (r.cnt != '0) && out_ready;
    if (push) begin
      n.mem[r.wr] = in_data;
      n.wr        = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + AW'(1);
    end
    if (pop) begin
      n.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + AW'(1);
    end
    n.cnt = r.cnt + CW'(push) - CW'(pop);
    n.rdy = (n.cnt != CW'(DEPTH));
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r     <= '0;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign in_ready  = r.rdy;
  assign out_valid = (r.cnt != '0);
  assign out_data  = r.mem[r.rd];

  full_block_a: assert property (@(posedge clk) disable iff (rst)
    !r.rdy |-> r.cnt == CW'(DEPTH))
    else $error("buffer refused a word while not full");
endmodule

// [hdl/plk_half_init.sv]
// Reset, training and width/rate bring-up of one link half
`timescale 1ns/10ps
module plk_half_init
  import plk_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Half control
  input  wire logic       enable,
  input  wire logic       master,
  input  wire logic       tick,
  input  wire logic       stop_n,
  input  wire logic       peer_up,
  input  wire logic       peer_ctl,
  input  wire logic       warm_req,
  // Settings waiting for the next re-initialisation
  input  wire logic       cfg_wide_out,
  input  wire logic       cfg_wide_in,
  input  wire logic [1:0] cfg_freq,
  // Results
  output logic            link_rst_n,
  output logic            ctl_drive,
  output logic            done,
  output logic            wide_out,
  output logic            wide_in,
  output logic [1:0]      freq
);
  typedef struct packed {
    plk_state_t state;
    logic [7:0] cnt;
    logic       cold;
    logic       stop_prev;
    logic       wo;
    logic       wi;
    logic [1:0] freq;
  } plk_init_t;

  plk_init_t r;
  plk_init_t n;
  logic      reinit;

  // Sequencer; re-entry to link reset loads the waiting settings, or 8 bits and 200 MHz from hold or while still cold
  always_comb begin
    n           = r;
    n.stop_prev = stop_n;
    reinit      = (r.state != PLK_HOLD) &&
                  (warm_req || (r.stop_prev && !stop_n) || (!master && !peer_up));
    unique case (r.state)
      PLK_HOLD: begin
        if (enable) begin
          n.state = PLK_LRST;
        end
      end
      PLK_LRST: begin
        if (r.cnt != 8'(LINK_RESET_CYCLES - 1)) begin
          n.cnt = r.cnt + 8'h01;
        end else if (master || peer_up) begin
          n.state = PLK_TRAIN;
          n.cnt   = 8'h00;
        end
      end
      PLK_TRAIN: begin
        if (tick) begin
          n.cnt = peer_ctl ? r.cnt + 8'h01 : 8'h00;
          if (peer_ctl && r.cnt == 8'(TRAIN_TICKS - 1)) begin
            n.state = PLK_UP;
            n.cold  = 1'b0;
          end
        end
      end
      PLK_UP: begin
        n.cnt = 8'h00;
      end
    endcase
    if (reinit || (r.state == PLK_HOLD && enable)) begin
      n.state = PLK_LRST;
      n.cnt   = 8'h00;
      if (r.cold || r.state == PLK_HOLD) begin
        n.wo   = WIDTH_8;
        n.wi   = WIDTH_8;
        n.freq = FREQ_200;
      end else begin
        n.wo   = cfg_wide_out;
        n.wi   = cfg_wide_in;
        n.freq = (cfg_freq == FREQ_800 || cfg_freq == FREQ_400) ? cfg_freq : FREQ_200;
      end
    end
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      r       <= '0;
      r.state <= PLK_HOLD;
      r.cold  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign link_rst_n = (r.state == PLK_TRAIN) || (r.state == PLK_UP);
  assign ctl_drive  = (r.state == PLK_TRAIN) || (r.state == PLK_UP);
  assign done       = (r.state == PLK_UP);
  assign wide_out   = r.wo;
  assign wide_in    = r.wi;
  assign freq       = r.freq;

  cold_width_a: assert property (@(posedge clk) disable iff (rst)
    (r.state == PLK_LRST && r.cold) |-> (r.wo == WIDTH_8 && r.freq == FREQ_200))
    else $error("cold start not at narrowest width and lowest rate");
  done_train_a: assert property (@(posedge clk) disable iff (rst)
    $rose(done) |-> $past(r.state) == PLK_TRAIN && $past(r.cnt) == 8'(TRAIN_TICKS - 1))
    else $error("link reported up without full training");
  warm_apply_a: assert property (@(posedge clk) disable iff (rst)
    ($changed(r.wo) || $changed(r.freq)) |-> r.state == PLK_LRST && r.cnt == 8'h00)
    else $error("link settings changed outside re-initialisation");
endmodule

// [dv/plk_peer_model.sv]
// Far-side peer chip model for the packet link
`timescale 1ns/10ps
module plk_peer_model (
  // Sideband drive from the device
  input  wire logic [1:0] pg_oe,
  input  wire logic [1:0] pg_out,
  input  wire logic [1:0] rs_oe,
  input  wire logic [1:0] rs_out,
  // Lines seen by the device
  output logic            lclk,
  output logic [1:0]      rx_ctl,
  output logic [1:0]      pg_in,
  output logic [1:0]      rs_in
);
  // Forwarded clock runs free
  initial begin
    lclk = 1'b0;
    forever #160 lclk = ~lclk;
  end
  // Peer drives a slave half's lines high
  assign pg_in = (pg_oe & pg_out) | ~pg_oe;
  assign rs_in = (rs_oe & rs_out) | ~rs_oe;
  // Training starts once link reset lifts, same settings both ends
  assign rx_ctl = rs_in;
endmodule

// [dv/plk_link_setup_tb_top.sv]
// Self-checking bench of the packet link setup block
`timescale 1ns/10ps
module plk_link_setup_tb_top;
  import plk_pkg::*;
  typedef struct packed {logic hi; logic hit; logic [2:0] ex;} plk_row_t;
  logic clk, rst, spl, lom, him, av, rv, rh, rt, full;
  logic [47:0] aa;
  logic [15:0] ad;
  logic [1:0] we, wd, wm, cwo, cwi, stp, req, rdy, role, brg, ic, lwo, lwi, prq;
  logic [1:0] tclk, tctl, pgi, pgo, pgoe, rsi, rso, rsoe, spo, spoe, rxc;
  logic [3:0] cf, lf;
  logic [15:0] cad;
  logic lclk, drop, acc, p2p, er, sa, coh;
  int err_count, cmp_count;
  plk_row_t rows [4] = '{'{1'b0, 1'b1, 3'b100}, '{1'b0, 1'b0, 3'b010},
                         '{1'b1, 1'b0, 3'b001}, '{1'b1, 1'b1, 3'b100}};
  plk_link_setup DUT (.CLOCK(clk), .RESET(rst), .LINK_SPLIT_STRAP(spl),
    .LOW_HALF_MASTER_STRAP(lom), .HIGH_HALF_MASTER_STRAP(him), .LINK_CLK(lclk),
    .RX_CTL(rxc), .TX_CLK(tclk), .TX_CTL(tctl), .TX_CAD(cad), .POWER_GOOD_LINE_IN(pgi),
    .POWER_GOOD_LINE_OUT(pgo), .POWER_GOOD_LINE_OE(pgoe), .LINK_RESET_LINE_N_IN(rsi),
    .LINK_RESET_LINE_N_OUT(rso), .LINK_RESET_LINE_N_OE(rsoe), .LINK_STOP_LINE_N_IN(stp),
    .LINK_STOP_LINE_N_OUT(spo), .LINK_STOP_LINE_N_OE(spoe), .LINK_REQUEST_LINE_N_IN(req),
    .ACC_VALID(av), .ACC_ADDR(aa), .ACC_DATA(ad), .ACC_READY(rdy), .ACC_DROP(drop),
    .RXQ_VALID(rv), .RXQ_HIGH(rh), .RXQ_HIT(rt), .RXQ_ACCEPT(acc), .RXQ_P2P(p2p),
    .RXQ_ERROR(er), .ROLE_WE(we), .ROLE_WDATA(wd), .WARM_RESET(wm), .CFG_WIDTH_OUT(cwo),
    .CFG_WIDTH_IN(cwi), .CFG_FREQ(cf), .ENDPOINT_ROLE_FLAG(role), .BRIDGE_BIT(brg),
    .INIT_COMPLETE(ic), .LINK_WIDTH_OUT(lwo), .LINK_WIDTH_IN(lwi), .LINK_FREQ(lf),
    .PEER_REQUEST(prq), .SPLIT_ACTIVE(sa), .COHERENT(coh));
  plk_peer_model peer (.pg_oe(pgoe), .pg_out(pgo), .rs_oe(rsoe), .rs_out(rso),
    .lclk(lclk), .rx_ctl(rxc), .pg_in(pgi), .rs_in(rsi));
  // Clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask
  task step;
    @(posedge clk);
    #1;
  endtask
  // Bounded wait for bring-up of the masked halves
  task wait_init(input logic [1:0] m);
    for (int n = 0; n < 3000 && (ic & m) !== m; n++) step;
    chk(16'(ic & m), 16'(m));
  endtask
  task send(input logic [15:0] d);
    av = 1'b1;
    ad = d;
    for (int n = 0; n < 500 && rdy[aa[40]] !== 1'b1; n++) begin
      full = 1'b1;
      step;
    end
    step;
  endtask
  task see(input logic [3:0] sh, input logic [7:0] b);
    for (int n = 0; n < 300 && 8'(cad >> sh) !== b; n++) step;
    chk(16'(8'(cad >> sh)), 16'(b));
  endtask
  task tally_and_finish;
    if (err_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Watchdog against a hang
  initial begin
    #800000;
    err_count++;
    tally_and_finish;
  end
  // Main sequence; low half master, high half slave, low request line asserted
  initial begin
    {av, rv, rh, rt, full, aa, ad, we, wd, wm, cwo, cwi, cf} = '0;
    {spl, lom, him, stp, req} = 7'h6E;
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1 rst = 1'b0;
    repeat (5) step;
    chk(16'(role), 16'h2);
    chk(16'(brg), 16'h1);
    chk(16'({sa, coh}), 16'h3);
    chk(16'({rsoe & pgoe, rso[0]}), 16'h2);
    chk(16'({spoe, spo, pgo}), 16'h15);
    chk(16'(prq), 16'h1);
    wait_init(2'h3);
    chk(16'({lf, lwo, lwi}), 16'h0);
    // Back-to-back verdicts from the table
    foreach (rows[i]) begin
      {rv, rh, rt} = {1'b1, rows[i].hi, rows[i].hit};
      step;
      chk(16'({acc, p2p, er}), 16'(rows[i].ex));
    end
    // Role write beside a miss: that verdict still uses the old flag
    {we, wd, rv, rh, rt} = 7'h6C;
    step;
    {we, rv} = 3'h0;
    chk(16'({role, brg, acc, p2p, er}), 16'h32);
    rv = 1'b1;
    step;
    rv = 1'b0;
    chk(16'({acc, p2p, er}), 16'h1);
    fork
      begin
        send(16'hA5C3);
        send(16'h5A3C);
        send(16'h1E2D);
        av = 1'b0;
      end
      begin
        see(4'h0, 8'hC3);
        see(4'h0, 8'hA5);
        see(4'h0, 8'h3C);
        see(4'h0, 8'h5A);
        see(4'h0, 8'h2D);
        see(4'h0, 8'h1E);
      end
    join
    chk(16'(full), 16'h1);
    // High half word leaves on the upper lanes
    aa[40] = 1'b1;
    fork
      begin
        send(16'h4B69);
        av = 1'b0;
      end
      begin
        see(4'h8, 8'h69);
        see(4'h8, 8'h4B);
      end
    join
    {cf, wm} = 6'h1B;
    step;
    wm = 2'h0;
    step;
    step;
    chk(16'(ic), 16'h0);
    wait_init(2'h3);
    chk(16'(lf), 16'({FREQ_400, FREQ_800}));
    // Falling stop line re-initialises the low half only
    stp = 2'h2;
    repeat (4) step;
    stp = 2'h3;
    chk(16'(ic), 16'h2);
    {rst, spl, req} = 4'h8;
    repeat (3) step;
    rst = 1'b0;
    wait_init(2'h1);
    lom = 1'b0;
    {rv, rh, rt, av, aa[40]} = 5'h1F;
    step;
    {rv, av} = 2'h0;
    chk(16'({acc, p2p, er}), 16'h0);
    chk(16'({sa, drop, role[0], lwo[0]}), 16'h4);
    chk(16'({tclk[1] ^ tclk[0], tctl[1]}), 16'h0);
    chk(16'(prq), 16'h1);
    repeat (3) step;
    chk(16'({role[0], pgoe[0]}), 16'h1);
    // Wide low half after a warm reset with 16-bit settings
    aa[40] = 1'b0;
    {cwo, cwi, wm} = 6'h15;
    step;
    wm = 2'h0;
    repeat (2) step;
    wait_init(2'h1);
    chk(16'({lwo, lwi}), 16'h5);
    send(16'h96E1);
    av = 1'b0;
    see(4'h0, 8'hE1);
    chk(16'(cad), 16'h96E1);
    tally_and_finish;
  end
endmodule
